// ---- vlh_pkg.sv ----
// vlh_pkg: constants, enums and carriers for the local bus host port.
// assumes a 32-bit synchronous local bus with active-low byte-lane enables.

package vlh_pkg;

  // ==========================================================
  // address field
  localparam int ADDR_W     = 14;  // address bits 15..2
  localparam int DECODE_W   = 12;  // address bits 15..4
  localparam int DECODE_LSB = 2;   // bit 4 within the 15..2 field
  localparam int DATA_W     = 32;
  localparam int LANES      = 4;

  // ==========================================================
  // byte-lane enable patterns, bit 0 is lane 0
  localparam logic [3:0] BE_DWORD     = 4'h0;
  localparam logic [3:0] BE_LOW_WORD  = 4'hC;
  localparam logic [3:0] BE_HIGH_WORD = 4'h3;
  localparam logic [3:0] BE_BYTE0     = 4'hE;
  localparam logic [3:0] BE_BYTE1     = 4'hD;
  localparam logic [3:0] BE_BYTE2     = 4'hB;
  localparam logic [3:0] BE_BYTE3     = 4'h7;
  localparam logic [3:0] BE_NONE      = 4'hF;
  localparam logic [1:0] HALF_OFF     = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [3:0]  OE_RST   = 4'h0;

  typedef enum logic [1:0] {
    VLH_SZ_BYTE,
    VLH_SZ_WORD,
    VLH_SZ_DWORD,
    VLH_SZ_BAD
  } vlh_size_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [3:0]        be_n;
    logic              write;
    vlh_size_t         size;
    logic              hi_word;
    logic              data_port;
    logic [DATA_W-1:0] wdata;
  } vlh_req_t;

  localparam vlh_req_t REQ_RST = '{
    addr: '0, be_n: BE_NONE, write: 1'b0, size: VLH_SZ_BAD,
    hi_word: 1'b0, data_port: 1'b0, wdata: DATA_RST
  };

endpackage

// ---- vlh_host_port.sv ----
// vlh_host_port: local bus slave port of the controller, bus pins on the
// local bus clock, register-space requests handed to the core clock domain.
// assumes bus glue makes cycle_strobe_n and resolves the data and ready wires.
`timescale 1ns/10ps

module vlh_host_port
  import vlh_pkg::*;
#(
  parameter logic [DECODE_W-1:0] DECODE_BASE    = 12'h030,  // claimed io window
  parameter logic [ADDR_W-1:0]   DATA_PORT_ADDR = 14'h0002  // data port index
)(
  input  wire logic              clk,                 // core clock
  input  wire logic              resetn,              // async reset, low
  input  wire logic              local_bus_clock,     // bus clock
  input  wire logic              address_strobe_n,    // bus address strobe
  input  wire logic              cycle_strobe_n,      // delayed strobe
  input  wire logic              write_not_read,      // 1 write, 0 read
  input  wire logic              io_space_qualifier,  // low enables decode
  input  wire logic [ADDR_W-1:0] addr_in,             // address 15..2
  input  wire logic              byte_lane0_enable_n, // lane 0 enable
  input  wire logic              byte_lane1_enable_n, // lane 1 enable
  input  wire logic              byte_lane2_enable_n, // lane 2 enable
  input  wire logic              byte_lane3_enable_n, // lane 3 enable
  input  wire logic              ready_return_n,      // bus ready return
  input  wire logic [DATA_W-1:0] data_in,             // data pin level
  output logic      [DATA_W-1:0] data_out,            // data drive value
  output logic      [LANES-1:0]  data_oe,             // per-lane drive
  output logic                   local_device_claim_n,// claim, totem pole
  output logic                   sync_ready_n,        // ready pulse
  output vlh_req_t               core_req,            // request to core
  output logic                   core_req_valid,      // request pulse
  input  wire logic              core_rsp_valid,      // core done pulse
  input  wire logic [DATA_W-1:0] core_rdata           // core read data
);

  // ==========================================================
  // link reset: asserted at once, released on the bus clock
  logic lrst_meta_ff;
  logic lrst_n_ff;

  always_ff @(posedge local_bus_clock or negedge resetn)
  begin
    if (!resetn)
    begin
      lrst_meta_ff <= 1'b0;
      lrst_n_ff    <= 1'b0;
    end
    else
    begin
      lrst_meta_ff <= 1'b1;
      lrst_n_ff    <= lrst_meta_ff;
    end
  end

  // ==========================================================
  // address-phase latches
  // pins are already on the bus clock, so no synchroniser here
  logic [ADDR_W-1:0] addr_hold_ff;
  logic [3:0]        be_hold_ff;
  logic              qual_hold_ff;
  wire  [3:0]        be_pins_n;

  assign be_pins_n = {byte_lane3_enable_n, byte_lane2_enable_n,
                      byte_lane1_enable_n, byte_lane0_enable_n};

  always_ff @(posedge local_bus_clock or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      addr_hold_ff <= '0;
      be_hold_ff   <= BE_NONE;
      qual_hold_ff <= 1'b1;
    end
    else if (!address_strobe_n)
    begin
      addr_hold_ff <= addr_in;
      be_hold_ff   <= be_pins_n;
      qual_hold_ff <= io_space_qualifier;
    end
  end

  wire [ADDR_W-1:0] addr_live;
  wire [3:0]        be_live_n;
  wire              qual_live;

  // strobe low: pins pass; strobe high: last captured value holds
  assign addr_live = address_strobe_n ? addr_hold_ff : addr_in;
  assign be_live_n = address_strobe_n ? be_hold_ff : be_pins_n;
  assign qual_live = address_strobe_n ? qual_hold_ff : io_space_qualifier;

  // ==========================================================
  // decode
  wire decode_hit;
  wire nxt_claim_n;

  assign decode_hit  = (addr_live[ADDR_W-1:DECODE_LSB] == DECODE_BASE)
                       && !qual_live;
  assign nxt_claim_n = !decode_hit;

  // ==========================================================
  // lane decode
  vlh_size_t  size_dec;
  wire        hi_word_dec;
  wire [31:0] lane_mask;
  wire        is_data_port;

  assign size_dec =
    (be_live_n == BE_DWORD)                                ? VLH_SZ_DWORD :
    (be_live_n == BE_LOW_WORD || be_live_n == BE_HIGH_WORD) ? VLH_SZ_WORD :
    (be_live_n == BE_BYTE0 || be_live_n == BE_BYTE1 ||
     be_live_n == BE_BYTE2 || be_live_n == BE_BYTE3)       ? VLH_SZ_BYTE :
                                                             VLH_SZ_BAD;

  // address bit 1 is tied low, so lanes 0-1 off with a lane of 2-3 on picks the upper half
  assign hi_word_dec = (be_live_n[1:0] == HALF_OFF)
                       && (be_live_n[3:2] != HALF_OFF);

  assign lane_mask = {{8{!be_live_n[3]}}, {8{!be_live_n[2]}},
                      {8{!be_live_n[1]}}, {8{!be_live_n[0]}}};

  assign is_data_port = (addr_live == DATA_PORT_ADDR);

  // ==========================================================
  // cycle start: first bus clock edge with the cycle strobe low
  logic cyc_low_ff;
  wire  cyc_first;

  always_ff @(posedge local_bus_clock or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
      cyc_low_ff <= 1'b0;
    else
      cyc_low_ff <= !cycle_strobe_n;
  end

  // glue delays the address strobe by one clock to form this edge
  assign cyc_first = !cycle_strobe_n && !cyc_low_ff;

  // ==========================================================
  // link-side state machine
  typedef enum logic [1:0] {
    L_IDLE,
    L_WAIT,
    L_READY
  } vlh_lstate_t;

  vlh_lstate_t lstate_ff;
  vlh_lstate_t nxt_lstate;
  vlh_req_t    req_link_ff;
  vlh_req_t    nxt_req_link;
  logic        req_tog_ff;
  logic        claim_n_ff;
  logic        srdy_n_ff;
  logic [31:0] dout_ff;
  logic [3:0]  oe_ff;
  logic        ak_meta_ff;
  logic        ak_sync_ff;
  logic        ak_prev_ff;
  // core-domain toggle; read here only by the first sync stage
  logic        ack_tog_ff;
  logic [31:0] rdata_hold_ff;

  wire  take;
  wire  take_ok;
  wire  ack_seen;
  wire  go_ready;
  wire  end_xfer;

  assign take     = (lstate_ff == L_IDLE) && cyc_first && decode_hit;
  // a pattern outside the table gets a ready but moves no data
  assign take_ok  = take && (size_dec != VLH_SZ_BAD);
  assign ack_seen = ak_sync_ff ^ ak_prev_ff;
  assign go_ready = (lstate_ff == L_WAIT) && ack_seen;
  assign end_xfer = (lstate_ff == L_READY) && !ready_return_n;

  always_comb
  begin
    nxt_lstate = lstate_ff;
    case (lstate_ff)
      L_IDLE:
        if (take_ok)
          nxt_lstate = L_WAIT;
        else if (take)
          nxt_lstate = L_READY;
      L_WAIT:
        if (ack_seen)
          nxt_lstate = L_READY;
      L_READY:
        if (!ready_return_n)
          nxt_lstate = L_IDLE;
      default:
        nxt_lstate = L_IDLE;
    endcase
  end

  always_comb
  begin
    nxt_req_link           = req_link_ff;
    nxt_req_link.addr      = addr_live;
    nxt_req_link.be_n      = be_live_n;
    nxt_req_link.write     = write_not_read;
    nxt_req_link.size      = size_dec;
    nxt_req_link.hi_word   = hi_word_dec;
    nxt_req_link.data_port = is_data_port;
    nxt_req_link.wdata     = data_in & lane_mask;
  end

  always_ff @(posedge local_bus_clock or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      lstate_ff   <= L_IDLE;
      req_link_ff <= REQ_RST;
      req_tog_ff  <= 1'b0;
      claim_n_ff  <= 1'b1;
    end
    else
    begin
      lstate_ff  <= nxt_lstate;
      claim_n_ff <= nxt_claim_n;
      if (take)
        req_link_ff <= nxt_req_link;
      if (take_ok)
        req_tog_ff <= !req_tog_ff;
    end
  end

  // ==========================================================
  // ready and read data drive
  always_ff @(posedge local_bus_clock or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      srdy_n_ff <= 1'b1;
      dout_ff   <= DATA_RST;
      oe_ff     <= OE_RST;
    end
    else
    begin
      srdy_n_ff <= !(go_ready || (take && !take_ok));   // one-clock ready
      if (go_ready && !req_link_ff.write)
      begin
        dout_ff <= rdata_hold_ff;
        oe_ff   <= ~req_link_ff.be_n;
      end
      else if (end_xfer || lstate_ff == L_IDLE)
        oe_ff   <= OE_RST;
    end
  end

  // ==========================================================
  // ack toggle from the core domain
  always_ff @(posedge local_bus_clock or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      ak_meta_ff <= 1'b0;
      ak_sync_ff <= 1'b0;
      ak_prev_ff <= 1'b0;
    end
    else
    begin
      ak_meta_ff <= ack_tog_ff;
      ak_sync_ff <= ak_meta_ff;
      ak_prev_ff <= ak_sync_ff;
    end
  end

  assign data_out             = dout_ff;
  assign data_oe              = oe_ff;
  assign local_device_claim_n = claim_n_ff;
  assign sync_ready_n         = srdy_n_ff;

  // ==========================================================
  // core domain: request toggle in, response back
  // req_link_ff is held from the toggle until the ack returns,
  // so the whole word can be sampled once the toggle is seen
  logic     rq_meta_ff;
  logic     rq_sync_ff;
  logic     rq_prev_ff;
  logic     pend_ff;
  logic     req_valid_ff;
  vlh_req_t core_req_ff;

  wire new_req;
  wire rsp_take;

  assign new_req  = rq_sync_ff ^ rq_prev_ff;
  assign rsp_take = pend_ff && core_rsp_valid;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rq_meta_ff <= 1'b0;
      rq_sync_ff <= 1'b0;
      rq_prev_ff <= 1'b0;
    end
    else
    begin
      rq_meta_ff <= req_tog_ff;
      rq_sync_ff <= rq_meta_ff;
      rq_prev_ff <= rq_sync_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_valid_ff <= 1'b0;
      core_req_ff  <= REQ_RST;
      pend_ff      <= 1'b0;
    end
    else
    begin
      req_valid_ff <= new_req;
      if (new_req)
        core_req_ff <= req_link_ff;
      if (new_req)
        pend_ff <= 1'b1;
      else if (rsp_take)
        pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_tog_ff    <= 1'b0;
      rdata_hold_ff <= DATA_RST;
    end
    else if (rsp_take)
    begin
      ack_tog_ff    <= !ack_tog_ff;
      rdata_hold_ff <= core_rdata;
    end
  end

  assign core_req       = core_req_ff;
  assign core_req_valid = req_valid_ff;

endmodule

// ---- vlh_host_port_asserts.sv ----
// vlh_host_port_asserts: pin-level checks of the host port.
// assumes the bind below; one bus transfer at a time.
`timescale 1ns/10ps
module vlh_host_port_asserts
  import vlh_pkg::*;
#(
  parameter logic [DECODE_W-1:0] DECODE_BASE = 12'h030 // claimed window
)(
  input wire logic              clk,                  // core clock
  input wire logic              resetn,               // reset, low
  input wire logic              local_bus_clock,      // bus clock
  input wire logic              address_strobe_n,     // strobe
  input wire logic              cycle_strobe_n,       // cycle strobe
  input wire logic              io_space_qualifier,   // qualifier
  input wire logic [ADDR_W-1:0] addr_in,              // address
  input wire logic              byte_lane0_enable_n,  // lane 0
  input wire logic              byte_lane1_enable_n,  // lane 1
  input wire logic              byte_lane2_enable_n,  // lane 2
  input wire logic              byte_lane3_enable_n,  // lane 3
  input wire logic              ready_return_n,       // ready return
  input wire logic [LANES-1:0]  data_oe,              // lane drive
  input wire logic              local_device_claim_n, // claim
  input wire logic              sync_ready_n,         // ready
  input wire vlh_req_t          core_req,             // request
  input wire logic              core_req_valid        // request pulse
);
  // ==========================================================
  // helpers
  wire [3:0] be_n = {byte_lane3_enable_n, byte_lane2_enable_n,
                     byte_lane1_enable_n, byte_lane0_enable_n};
  wire hit = !io_space_qualifier && addr_in[ADDR_W-1:DECODE_LSB] == DECODE_BASE;
  wire be_ok = be_n inside {BE_DWORD, BE_LOW_WORD, BE_HIGH_WORD, BE_BYTE0,
                            BE_BYTE1, BE_BYTE2, BE_BYTE3};
  wire [3:0] rb = core_req.be_n;
  wire [DATA_W-1:0] wmask = {{8{rb[3]}}, {8{rb[2]}}, {8{rb[1]}}, {8{rb[0]}}};

  // ==========================================================
  // bus side
  property p_claim;
    @(posedge local_bus_clock) disable iff (!resetn)
      !address_strobe_n && hit |=> !local_device_claim_n;
  endproperty
  a_claim: assert property (p_claim) else $error("no claim on hit");
  property p_rdy;
    @(posedge local_bus_clock) disable iff (!resetn) !sync_ready_n |=> sync_ready_n;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready longer than one clock");
  property p_lanes;
    @(posedge local_bus_clock) disable iff (!resetn) |data_oe |-> (data_oe & be_n) == 4'h0;
  endproperty
  a_lanes: assert property (p_lanes) else $error("unselected lane driven");
  property p_rel;
    @(posedge local_bus_clock) disable iff (!resetn) !ready_return_n |=> data_oe == 4'h0;
  endproperty
  a_rel: assert property (p_rel) else $error("drive held past ready return");
  property p_bad;
    @(posedge local_bus_clock) disable iff (!resetn)
      $fell(cycle_strobe_n) && hit && !be_ok |-> ##[1:2] !sync_ready_n;
  endproperty
  a_bad: assert property (p_bad) else $error("odd enables not answered");

  // ==========================================================
  // core side
  property p_size;
    @(posedge clk) disable iff (!resetn)
      core_req_valid && rb == BE_DWORD |-> core_req.size == VLH_SZ_DWORD;
  endproperty
  a_size: assert property (p_size) else $error("dword size wrong");
  property p_hi;
    @(posedge clk) disable iff (!resetn)
      core_req_valid && core_req.size == VLH_SZ_WORD |-> core_req.hi_word == (rb == BE_HIGH_WORD);
  endproperty
  a_hi: assert property (p_hi) else $error("word half wrong");
  property p_wmask;
    @(posedge clk) disable iff (!resetn)
      core_req_valid && core_req.write |-> (core_req.wdata & wmask) == '0;
  endproperty
  a_wmask: assert property (p_wmask) else $error("unselected write lane kept");
  cover property (@(posedge local_bus_clock) $rose(|data_oe));
  cover property (@(posedge clk) core_req_valid && core_req.write);
  cover property (@(posedge local_bus_clock) $fell(cycle_strobe_n) && hit && !be_ok);
endmodule

bind vlh_host_port vlh_host_port_asserts #(.DECODE_BASE(DECODE_BASE)) u_chk (
  .clk(clk), .resetn(resetn), .local_bus_clock(local_bus_clock),
  .address_strobe_n(address_strobe_n), .cycle_strobe_n(cycle_strobe_n),
  .io_space_qualifier(io_space_qualifier), .addr_in(addr_in),
  .byte_lane0_enable_n(byte_lane0_enable_n), .byte_lane1_enable_n(byte_lane1_enable_n),
  .byte_lane2_enable_n(byte_lane2_enable_n), .byte_lane3_enable_n(byte_lane3_enable_n),
  .ready_return_n(ready_return_n), .data_oe(data_oe),
  .local_device_claim_n(local_device_claim_n), .sync_ready_n(sync_ready_n),
  .core_req(core_req), .core_req_valid(core_req_valid));

// ---- vlh_bus_master.sv ----
// vlh_bus_master: local bus master with its glue, for the bench.
// assumes xfer is called by one process, one transfer at a time.
`timescale 1ns/10ps
module vlh_bus_master
  import vlh_pkg::*;
(
  input  wire logic              local_bus_clock,    // bus clock
  input  wire logic [DATA_W-1:0] data_out,           // port drive value
  input  wire logic [LANES-1:0]  data_oe,            // port lane drive
  input  wire logic              sync_ready_n,       // port ready
  output logic                   address_strobe_n,   // strobe
  output logic                   cycle_strobe_n,     // delayed strobe
  output logic                   write_not_read,     // direction
  output logic                   io_space_qualifier, // qualifier
  output logic      [ADDR_W-1:0] addr_in,            // address 15..2
  output logic      [3:0]        be_n,               // lane enables
  output logic                   ready_return_n,     // ready return
  output logic      [DATA_W-1:0] data_in             // resolved data
);
  logic [DATA_W-1:0] wdat;
  logic [DATA_W-1:0] junk;
  logic              drv;
  wire  [DATA_W-1:0] oe_m = {{8{data_oe[3]}}, {8{data_oe[2]}}, {8{data_oe[1]}}, {8{data_oe[0]}}};
  // no keeper on the wire: a released lane must not look like valid data
  assign data_in = (oe_m & data_out) | (~oe_m & (drv ? wdat : junk));
  initial
  begin
    {address_strobe_n, cycle_strobe_n, ready_return_n, write_not_read} = 4'hE;
    {io_space_qualifier, drv, addr_in, be_n} = {2'h2, 14'h0000, BE_NONE};
    {wdat, junk} = {32'h0000_0000, 32'h5A5A_5A5A};
  end
  always @(posedge local_bus_clock) junk <= ~junk;

  task automatic xfer(input logic w, input logic q, input logic [ADDR_W-1:0] a,
                      input logic [3:0] be, input logic [DATA_W-1:0] wd,
                      output logic [DATA_W-1:0] rd, output logic ok);
    ok = 1'b0;
    rd = '0;
    @(posedge local_bus_clock);
    address_strobe_n <= 1'b0;
    {addr_in, be_n, io_space_qualifier, wdat} <= {a, be, q, wd};
    write_not_read <= w;
    drv <= w;
    @(posedge local_bus_clock);
    address_strobe_n <= 1'b1;
    cycle_strobe_n <= 1'b0;
    for (int n = 0; n < 60 && !ok; n++)
    begin
      @(posedge local_bus_clock);
      ok = (sync_ready_n === 1'b0);
      rd = data_in;
    end
    ready_return_n <= 1'b0;
    cycle_strobe_n <= 1'b1;
    @(posedge local_bus_clock);
    ready_return_n <= 1'b1;
    drv <= 1'b0;
  endtask
endmodule

// ---- testbench.sv ----
// testbench: host port scenarios; the bench stands in for the core.
// assumes vlh_bus_master as the bus side and the bound checker.
`timescale 1ns/10ps
module testbench;
  import vlh_pkg::*;
  localparam logic [ADDR_W-1:0] A_DATA = 14'h00C2;
  logic clk, resetn, lbc, core_rsp_valid, ok, as_n, cs_n, wnr, q, rr_n, srdy_n, claim_n, rv;
  logic [ADDR_W-1:0] addr;
  logic [3:0]        be_n, oe;
  logic [DATA_W-1:0] din, dout, core_rdata, rd;
  vlh_req_t          req, last_req;
  int                fail_count, cmp_count;
  int                req_cnt = 0;

  vlh_bus_master bm (.local_bus_clock(lbc), .data_out(dout), .data_oe(oe), .sync_ready_n(srdy_n),
    .address_strobe_n(as_n), .cycle_strobe_n(cs_n), .write_not_read(wnr),
    .io_space_qualifier(q), .addr_in(addr), .be_n(be_n), .ready_return_n(rr_n), .data_in(din));
  vlh_host_port #(.DECODE_BASE(12'h030), .DATA_PORT_ADDR(A_DATA)) dut (.clk(clk),
    .resetn(resetn), .local_bus_clock(lbc), .address_strobe_n(as_n), .cycle_strobe_n(cs_n),
    .write_not_read(wnr), .io_space_qualifier(q), .addr_in(addr),
    .byte_lane0_enable_n(be_n[0]), .byte_lane1_enable_n(be_n[1]),
    .byte_lane2_enable_n(be_n[2]), .byte_lane3_enable_n(be_n[3]), .ready_return_n(rr_n),
    .data_in(din), .data_out(dout), .data_oe(oe), .local_device_claim_n(claim_n),
    .sync_ready_n(srdy_n), .core_req(req), .core_req_valid(rv),
    .core_rsp_valid(core_rsp_valid), .core_rdata(core_rdata));

  function automatic logic [DATA_W-1:0] rd_of(input logic [ADDR_W-1:0] a);
    return {a, 4'h6, a};
  endfunction
  function automatic logic [DATA_W-1:0] m_of(input logic [3:0] b);
    return ~{{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction
  // core stand-in: answers every request one clock later
  always @(posedge clk)
  begin
    core_rsp_valid <= (rv === 1'b1);
    core_rdata <= rd_of(req.addr);
    if (rv === 1'b1)
    begin
      last_req <= req;
      req_cnt <= req_cnt + 1;
    end
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string s);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic t_read();
    logic [3:0] t [7] = '{BE_DWORD, BE_LOW_WORD, BE_HIGH_WORD, BE_BYTE0,
                          BE_BYTE1, BE_BYTE2, BE_BYTE3};
    vlh_size_t  sz;
    for (int i = 0; i < 7; i++)
    begin
      sz = i == 0 ? VLH_SZ_DWORD : i < 3 ? VLH_SZ_WORD : VLH_SZ_BYTE;
      bm.xfer(1'b0, 1'b0, A_DATA, t[i], '0, rd, ok);
      chk(32'(ok), 1, "read ready");
      chk(rd & m_of(t[i]), rd_of(A_DATA) & m_of(t[i]), "read lanes");
      chk(32'(last_req.size), 32'(sz), "size");
      chk({last_req.write, last_req.data_port, claim_n}, 3'h2, "rd/claim");
      if (i inside {1, 2})
        chk(32'(last_req.hi_word), 32'(i == 2), "half");
    end
    $display("t_read done");
  endtask
  task automatic t_write();
    logic [3:0] t [3] = '{BE_DWORD, BE_HIGH_WORD, BE_BYTE1};
    logic [3:0] b;
    for (int i = 0; i < 4; i++)
    begin
      // the non-data register only ever sees a word access
      b = i < 3 ? t[i] : BE_LOW_WORD;
      bm.xfer(1'b1, 1'b0, i < 3 ? A_DATA : 14'h00C1, b, 32'h1122_3344, rd, ok);
      chk({ok, last_req.write, last_req.data_port}, {2'h3, i < 3}, "write");
      chk(last_req.wdata, 32'h1122_3344 & m_of(b), "wdata");
    end
    $display("t_write done");
  endtask
  task automatic t_refuse();
    int n = req_cnt;
    bm.xfer(1'b0, 1'b0, A_DATA, 4'h5, '0, rd, ok);
    chk({ok, 31'(req_cnt - n)}, {1'b1, 31'h0}, "odd enables");
    bm.xfer(1'b0, 1'b1, A_DATA, BE_DWORD, '0, rd, ok);
    chk({ok, claim_n, 30'(req_cnt - n)}, {2'h1, 30'h0}, "qualifier high");
    bm.xfer(1'b0, 1'b0, 14'h00D2, BE_DWORD, '0, rd, ok);
    chk({ok, claim_n, 30'(req_cnt - n)}, {2'h1, 30'h0}, "wrong window");
    $display("t_refuse done");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    lbc = 1'b0;
    #7;
    forever #16 lbc = ~lbc;
  end
  initial
  begin
    #400_000;
    fail_count++;
    test_done();
  end
  initial
  begin
    {resetn, fail_count, cmp_count} = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge lbc);
    chk({oe, claim_n, srdy_n, rv}, 7'h06, "reset state");
    t_read();
    t_write();
    t_refuse();
    test_done();
  end
endmodule
